// ===== hdl/srs_status_sync.sv
// Status byte, event status, SCPI summaries and completion handshake.
// Assumes command strobes and all status inputs share the clock domain.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// Operation
// - Completion command sets OPC after pending work
// - Enable bit 0 routes OPC into ESB
// - Enable value 32 lets ESB request service
// - Enable value 16 lets MAV request service
// - Completion query holds, then queues value 1
// - Wait command holds commands until work done
// - Event status LSB one means work finished
// - Aborted query queues error -410
// - Status byte and enable form top level
// - Status byte gathers ESB and SCPI summaries
// - SCPI registers share one template
// - Individual status is parallel-enable masked byte
// - MAV follows output buffer holding reply
// - Status and error queue readable remotely
// - Enable bit 6 ignored; rising bits request
// - Event reads clear; enables keep values
// - MSS set while service requested
module srs_status_sync #(
    parameter int ERR_DEPTH = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic cmd_opc,
    input wire logic cmd_opc_query,
    input wire logic cmd_wait,
    input wire logic ops_pending,
    input wire logic query_abort,
    input wire logic error_push,
    input wire logic [15:0] error_code,
    input wire logic [7:0] esr_events,
    input wire logic out_buf_avail,
    input wire logic [15:0] oper_cond,
    input wire logic [15:0] ques_cond,
    output logic cmd_hold,
    output logic reply_push,
    output logic [7:0] reply_data,
    output logic srq,
    output logic ist,
    output logic irq
);
    localparam int CW = $clog2(ERR_DEPTH + 1);
    localparam int PW = (ERR_DEPTH > 1) ? $clog2(ERR_DEPTH) : 1;
    localparam logic [CW-1:0] ERR_FULL = CW'(ERR_DEPTH);
    localparam logic [CW-1:0] ONE_C = CW'(1);
    localparam logic [PW-1:0] ONE_P = PW'(1);
    localparam logic [PW-1:0] LAST_P = PW'(ERR_DEPTH - 1);

    // Synchronisation state machine.
    srs_pkg::srs_state_e state;
    srs_pkg::srs_state_e next_state;
    // Event status, its enable, service enable and parallel poll enable.
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] ppe;
    // Assembled status byte and the masked bits that may request service.
    logic [7:0] stb;
    logic [7:0] srq_bits;
    logic [7:0] srq_prev;
    // Interrupt status and mask.
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [2:0] irq_set;
    // Error queue storage and pointers.
    logic [15:0] err_mem [ERR_DEPTH];
    logic [PW-1:0] err_head;
    logic [PW-1:0] err_tail;
    logic [CW-1:0] err_count;
    // Operation complete is reached in this cycle.
    logic opc_set;
    // Decoded register strobes.
    logic esr_rd;
    logic errq_rd;
    logic err_in;
    logic [15:0] err_word;
    logic err_pop;
    logic err_put;
    // SCPI register outputs.
    logic [15:0] op_ptr, op_ntr, op_evt, op_en;
    logic [15:0] qu_ptr, qu_ntr, qu_evt, qu_en;
    logic op_sum;
    logic qu_sum;

    // Operation register instance.
    srs_scpi_reg #(.WIDTH(16)) u_oper (
        .clock(clock),
        .sys_rst(sys_rst),
        .cond(oper_cond),
        .wdata(reg_wdata),
        .ptr_wr(reg_wr && reg_addr == srs_pkg::ADDR_OPER_PTR),
        .ntr_wr(reg_wr && reg_addr == srs_pkg::ADDR_OPER_NTR),
        .en_wr(reg_wr && reg_addr == srs_pkg::ADDR_OPER_EN),
        .event_rd(reg_rd && reg_addr == srs_pkg::ADDR_OPER_EVT),
        .ptr(op_ptr),
        .ntr(op_ntr),
        .event_bits(op_evt),
        .enable(op_en),
        .summary(op_sum)
    );

    // Questionable register instance, same template.
    srs_scpi_reg #(.WIDTH(16)) u_ques (
        .clock(clock),
        .sys_rst(sys_rst),
        .cond(ques_cond),
        .wdata(reg_wdata),
        .ptr_wr(reg_wr && reg_addr == srs_pkg::ADDR_QUES_PTR),
        .ntr_wr(reg_wr && reg_addr == srs_pkg::ADDR_QUES_NTR),
        .en_wr(reg_wr && reg_addr == srs_pkg::ADDR_QUES_EN),
        .event_rd(reg_rd && reg_addr == srs_pkg::ADDR_QUES_EVT),
        .ptr(qu_ptr),
        .ntr(qu_ntr),
        .event_bits(qu_evt),
        .enable(qu_en),
        .summary(qu_sum)
    );

    assign esr_rd = reg_rd && reg_addr == srs_pkg::ADDR_ESR;
    assign errq_rd = reg_rd && reg_addr == srs_pkg::ADDR_ERRQ;
    // Completion is reached once nothing overlapped is still running.
    assign opc_set = (state == srs_pkg::SRS_OPC_WAIT) && !ops_pending;
    // An aborted query takes precedence over a plain error push.
    assign err_in = query_abort || error_push;
    assign err_word = query_abort ? srs_pkg::ERR_QUERY_INT : error_code;
    assign err_pop = errq_rd && err_count != '0;
    // A full queue drops the new entry unless a read pops one in the same cycle.
    assign err_put = err_in && (err_count != ERR_FULL || err_pop);

    // Status byte assembly from all lower-level summaries.
    always_comb begin
        stb = 8'h00;
        stb[srs_pkg::STB_ERRQ] = err_count != '0;
        stb[srs_pkg::STB_QUES] = qu_sum;
        stb[srs_pkg::STB_MAV] = out_buf_avail;
        stb[srs_pkg::STB_ESB] = |(esr & ese);
        stb[srs_pkg::STB_MSS] = srq;
        stb[srs_pkg::STB_OPER] = op_sum;
    end

    // Bits that may request service; bit 6 never takes part.
    always_comb begin
        srq_bits = stb & sre;
        srq_bits[srs_pkg::STB_MSS] = 1'b0;
    end

    // Next state of the synchronisation machine.
    always_comb begin
        next_state = state;
        case (state)
            srs_pkg::SRS_IDLE: begin
                if (cmd_opc_query) begin
                    next_state = srs_pkg::SRS_QRY_WAIT;
                end else if (cmd_wait) begin
                    next_state = srs_pkg::SRS_WAI_WAIT;
                end else if (cmd_opc) begin
                    next_state = srs_pkg::SRS_OPC_WAIT;
                end
            end
            srs_pkg::SRS_OPC_WAIT: begin
                // Commands keep flowing while the completion is awaited.
                if (!ops_pending) begin
                    next_state = srs_pkg::SRS_IDLE;
                end
            end
            srs_pkg::SRS_QRY_WAIT, srs_pkg::SRS_WAI_WAIT: begin
                if (!ops_pending) begin
                    next_state = srs_pkg::SRS_IDLE;
                end
            end
            default: begin
                next_state = srs_pkg::SRS_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= srs_pkg::SRS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The parser is held while a query or a wait is outstanding.
    assign cmd_hold = state == srs_pkg::SRS_QRY_WAIT ||
        state == srs_pkg::SRS_WAI_WAIT;

    // Reply of the completion query: value 1 once work is done.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reply_push <= 1'b0;
            reply_data <= 8'h00;
        end else begin
            reply_push <= state == srs_pkg::SRS_QRY_WAIT && !ops_pending;
            if (state == srs_pkg::SRS_QRY_WAIT && !ops_pending) begin
                reply_data <= srs_pkg::REPLY_DONE;
            end
        end
    end

    // Event status register: sticky, read clears, new events win.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            esr <= 8'h00;
        end else begin
            if (esr_rd) begin
                esr <= esr_events;
            end else begin
                esr <= esr | esr_events;
            end
            if (opc_set) begin
                esr[srs_pkg::ESR_OPC] <= 1'b1;
            end
        end
    end

    // Enable masks keep their values when read.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ese <= 8'h00;
            sre <= 8'h00;
            ppe <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == srs_pkg::ADDR_ESE) begin
                ese <= reg_wdata[7:0];
            end else if (reg_addr == srs_pkg::ADDR_SRE) begin
                sre <= reg_wdata[7:0];
            end else if (reg_addr == srs_pkg::ADDR_PPE) begin
                ppe <= reg_wdata[7:0];
            end
        end
    end

    // Service request: a newly set enabled bit raises it; it drops once
    // no enabled bit remains set.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            srq <= 1'b0;
            srq_prev <= 8'h00;
        end else begin
            srq_prev <= srq_bits;
            if (|(srq_bits & ~srq_prev)) begin
                srq <= 1'b1;
            end else if (srq_bits == 8'h00) begin
                srq <= 1'b0;
            end
        end
    end

    // Individual status: parallel-enable masked status byte.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ist <= 1'b0;
        end else begin
            ist <= |(stb & ppe);
        end
    end

    // Error queue pointers and count.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            err_head <= '0;
            err_tail <= '0;
            err_count <= '0;
        end else begin
            if (err_put) begin
                err_tail <= (err_tail == LAST_P) ? '0 : err_tail + ONE_P;
            end
            if (err_pop) begin
                err_head <= (err_head == LAST_P) ? '0 : err_head + ONE_P;
            end
            if (err_put && !err_pop) begin
                err_count <= err_count + ONE_C;
            end else if (err_pop && !err_put) begin
                err_count <= err_count - ONE_C;
            end
        end
    end

    // Error queue storage.
    always_ff @(posedge clock) begin
        if (err_put) begin
            err_mem[err_tail] <= err_word;
        end
    end

    // Interrupt events: completion reached, service raised, error queued.
    assign irq_set = {err_put, srq_bits != 8'h00 && |(srq_bits & ~srq_prev),
        opc_set};

    // Sticky interrupt status, write one to clear, set wins.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == srs_pkg::ADDR_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~reg_wdata[2:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
            if (reg_wr && reg_addr == srs_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= reg_wdata[2:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == srs_pkg::ADDR_STB) begin
            reg_rdata <= {8'h00, stb};
        end else if (reg_addr == srs_pkg::ADDR_SRE) begin
            reg_rdata <= {8'h00, sre};
        end else if (reg_addr == srs_pkg::ADDR_ESR) begin
            reg_rdata <= {8'h00, esr};
        end else if (reg_addr == srs_pkg::ADDR_ESE) begin
            reg_rdata <= {8'h00, ese};
        end else if (reg_addr == srs_pkg::ADDR_PPE) begin
            reg_rdata <= {8'h00, ppe};
        end else if (reg_addr == srs_pkg::ADDR_ERRQ) begin
            reg_rdata <= (err_count != '0) ? err_mem[err_head] : 16'h0000;
        end else if (reg_addr == srs_pkg::ADDR_OPER_COND) begin
            reg_rdata <= oper_cond;
        end else if (reg_addr == srs_pkg::ADDR_OPER_PTR) begin
            reg_rdata <= op_ptr;
        end else if (reg_addr == srs_pkg::ADDR_OPER_NTR) begin
            reg_rdata <= op_ntr;
        end else if (reg_addr == srs_pkg::ADDR_OPER_EVT) begin
            reg_rdata <= op_evt;
        end else if (reg_addr == srs_pkg::ADDR_OPER_EN) begin
            reg_rdata <= op_en;
        end else if (reg_addr == srs_pkg::ADDR_QUES_COND) begin
            reg_rdata <= ques_cond;
        end else if (reg_addr == srs_pkg::ADDR_QUES_PTR) begin
            reg_rdata <= qu_ptr;
        end else if (reg_addr == srs_pkg::ADDR_QUES_NTR) begin
            reg_rdata <= qu_ntr;
        end else if (reg_addr == srs_pkg::ADDR_QUES_EVT) begin
            reg_rdata <= qu_evt;
        end else if (reg_addr == srs_pkg::ADDR_QUES_EN) begin
            reg_rdata <= qu_en;
        end else if (reg_addr == srs_pkg::ADDR_IRQ_STAT) begin
            reg_rdata <= {13'h0000, irq_stat};
        end else if (reg_addr == srs_pkg::ADDR_IRQ_MASK) begin
            reg_rdata <= {13'h0000, irq_mask};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Checks on the completion handshake and the status byte.
    AST_OPC_SET: assert property (@(posedge clock) disable iff (sys_rst)
        opc_set |=> esr[srs_pkg::ESR_OPC] &&
        state == srs_pkg::SRS_IDLE)
        else $error("Completion did not set the OPC event bit.");
    AST_ESB_SUM: assert property (@(posedge clock) disable iff (sys_rst)
        stb[srs_pkg::STB_ESB] == |(esr & ese))
        else $error("Event summary differs from masked events.");
    AST_QRY_REPLY: assert property (@(posedge clock) disable iff (sys_rst)
        (state == srs_pkg::SRS_QRY_WAIT && !ops_pending) |=>
        reply_push && reply_data == srs_pkg::REPLY_DONE && !cmd_hold)
        else $error("Completion query did not queue its reply.");
    AST_WAI_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        (state == srs_pkg::SRS_IDLE && cmd_wait && !cmd_opc_query) |=>
        cmd_hold)
        else $error("Wait command did not hold the parser.");
    AST_SRQ_RISE: assert property (@(posedge clock) disable iff (sys_rst)
        |(srq_bits & ~srq_prev) |=> srq ##0 stb[srs_pkg::STB_MSS])
        else $error("Rising enabled bit did not request service.");
    AST_SRQ_NO6: assert property (@(posedge clock) disable iff (sys_rst)
        (!srq && (stb & sre & 8'hBF) == 8'h00) |=> !srq)
        else $error("Service requested with no enabled bit set.");
    AST_MAV: assert property (@(posedge clock) disable iff (sys_rst)
        stb[srs_pkg::STB_MAV] == out_buf_avail)
        else $error("MAV does not follow the output buffer.");
    AST_ESR_CLR: assert property (@(posedge clock) disable iff (sys_rst)
        (esr_rd && esr_events == 8'h00 && !opc_set) |=> esr == 8'h00)
        else $error("Event status read did not clear it.");
    AST_ERR_410: assert property (@(posedge clock) disable iff (sys_rst)
        (query_abort && err_count == '0 && !errq_rd) |=>
        err_count == ONE_C &&
        err_mem[err_head] == srs_pkg::ERR_QUERY_INT)
        else $error("Aborted query did not queue error -410.");
    AST_IST: assert property (@(posedge clock) disable iff (sys_rst)
        ##1 ist == |($past(stb) & $past(ppe)))
        else $error("Individual status does not match masked byte.");

    COV_OPC: cover property (@(posedge clock) disable iff (sys_rst)
        opc_set ##2 srq);
    COV_QRY: cover property (@(posedge clock) disable iff (sys_rst)
        state == srs_pkg::SRS_QRY_WAIT ##1 reply_push);
    COV_ERR: cover property (@(posedge clock) disable iff (sys_rst)
        query_abort ##1 stb[srs_pkg::STB_ERRQ]);
endmodule : srs_status_sync

// ===== common/srs_pkg.sv
// Shared constants for the status report and synchronisation block.
// Assumes a 16-bit register port with word-aligned byte offsets.
package srs_pkg;
    // Register byte offsets on the register port.
    localparam logic [7:0] ADDR_STB = 8'h00;
    localparam logic [7:0] ADDR_SRE = 8'h04;
    localparam logic [7:0] ADDR_ESR = 8'h08;
    localparam logic [7:0] ADDR_ESE = 8'h0C;
    localparam logic [7:0] ADDR_PPE = 8'h10;
    localparam logic [7:0] ADDR_ERRQ = 8'h14;
    localparam logic [7:0] ADDR_OPER_COND = 8'h18;
    localparam logic [7:0] ADDR_OPER_PTR = 8'h1C;
    localparam logic [7:0] ADDR_OPER_NTR = 8'h20;
    localparam logic [7:0] ADDR_OPER_EVT = 8'h24;
    localparam logic [7:0] ADDR_OPER_EN = 8'h28;
    localparam logic [7:0] ADDR_QUES_COND = 8'h2C;
    localparam logic [7:0] ADDR_QUES_PTR = 8'h30;
    localparam logic [7:0] ADDR_QUES_NTR = 8'h34;
    localparam logic [7:0] ADDR_QUES_EVT = 8'h38;
    localparam logic [7:0] ADDR_QUES_EN = 8'h3C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
    // Status byte bit positions.
    localparam int STB_ERRQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int STB_OPER = 7;
    // Event status register bit that marks operation complete.
    localparam int ESR_OPC = 0;
    // Interrupt status bit positions.
    localparam int IRQ_OPC = 0;
    localparam int IRQ_SRQ = 1;
    localparam int IRQ_ERR = 2;
    // Reset values of the SCPI transition filters.
    localparam logic [15:0] PTR_RESET = 16'hFFFF;
    localparam logic [15:0] NTR_RESET = 16'h0000;
    // Error code left behind by a query that the controller aborted.
    localparam logic [15:0] ERR_QUERY_INT = 16'hFE66;
    // Reply byte placed in the output queue by the completion query.
    localparam logic [7:0] REPLY_DONE = 8'h01;
    // Synchronisation states, one-hot.
    typedef enum logic [3:0] {
        SRS_IDLE = 4'h1,
        SRS_OPC_WAIT = 4'h2,
        SRS_QRY_WAIT = 4'h4,
        SRS_WAI_WAIT = 4'h8
    } srs_state_e;
endpackage : srs_pkg

// ===== hdl/srs_scpi_reg.sv
// One SCPI status register: condition, transition filters, event, enable.
// Assumes condition bits come from logic on the same clock.
`timescale 1ns/1ns
module srs_scpi_reg #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] cond,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic ptr_wr,
    input wire logic ntr_wr,
    input wire logic en_wr,
    input wire logic event_rd,
    output logic [WIDTH-1:0] ptr,
    output logic [WIDTH-1:0] ntr,
    output logic [WIDTH-1:0] event_bits,
    output logic [WIDTH-1:0] enable,
    output logic summary
);
    // Condition value of the previous cycle, for edge detection.
    logic [WIDTH-1:0] cond_prev;
    // Bits whose transition passes a filter in this cycle.
    logic [WIDTH-1:0] hits;

    assign hits = (cond & ~cond_prev & ptr) | (~cond & cond_prev & ntr);
    // Summary is the OR of enabled event bits.
    assign summary = |(event_bits & enable);

    // Filters and enable keep their values when read.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ptr <= srs_pkg::PTR_RESET;
            ntr <= srs_pkg::NTR_RESET;
            enable <= '0;
            cond_prev <= '0;
        end else begin
            cond_prev <= cond;
            if (ptr_wr) begin
                ptr <= wdata;
            end
            if (ntr_wr) begin
                ntr <= wdata;
            end
            if (en_wr) begin
                enable <= wdata;
            end
        end
    end

    // Event bits are sticky; a read clears them but new hits win.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            event_bits <= '0;
        end else if (event_rd) begin
            event_bits <= hits;
        end else begin
            event_bits <= event_bits | hits;
        end
    end

    AST_EVT_RISE: assert property (@(posedge clock) disable iff (sys_rst)
        (|(cond & ~cond_prev & ptr)) |=> (|event_bits))
        else $error("Filtered rising condition did not set an event.");
endmodule : srs_scpi_reg

// ===== verification/srs_ctrl_model.sv
// Remote side model: overlapped work timer and the output buffer.
// Assumes start and read pulses come from the bench on the same clock.
`timescale 1ns/1ns
module srs_ctrl_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic reply_push,
    input wire logic buf_read,
    output logic ops_pending,
    output logic out_buf_avail
);
    logic [3:0] left; // Cycles of overlapped work still to run.
    // Each start pulse launches work of a fixed span.
    always_ff @(posedge clock) begin
        if (sys_rst)
            left <= 4'h0;
        else if (start)
            left <= 4'h6;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    assign ops_pending = (left != 4'h0);
    // A reply stays readable until the controller fetches it.
    always_ff @(posedge clock) begin
        if (sys_rst || buf_read)
            out_buf_avail <= 1'b0;
        else if (reply_push)
            out_buf_avail <= 1'b1;
    end
endmodule : srs_ctrl_model

// ===== verification/srs_status_sync_test.sv
// Self-checking bench for the status and synchronisation block.
// Assumes one 50 MHz clock and the remote model beside the block.
`timescale 1ns/1ns
module srs_status_sync_test;
    logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, esr_events = 8'h00, reply_data;
    logic [15:0] reg_wdata = 16'h0000, error_code = 16'h0000, reg_rdata;
    logic [15:0] oper_cond = 16'h0000, ques_cond = 16'h0000, code;
    logic [6:0] pul = 7'h00; // Command, error, work and buffer pulses.
    logic ops_pending, out_buf_avail, cmd_hold, reply_push, srq, ist, irq;
    logic rd_d = 1'b0; // A read was taken in the previous cycle.
    logic [15:0] rd_q[$]; // Expected read data, oldest first.
    logic [7:0] rp_q[$]; // Expected reply bytes, oldest first.
    int fail_count = 0, check_count = 0, cycles = 0, n;
    integer seed = 32'h606382a7;
    wire cmd_opc = pul[0];
    wire cmd_opc_query = pul[1];
    wire cmd_wait = pul[2];
    wire query_abort = pul[3];
    wire error_push = pul[4];
    wire start = pul[5];
    wire buf_read = pul[6];
    srs_status_sync srs_status_sync_i (.clock, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_opc, .cmd_opc_query,
        .cmd_wait, .ops_pending, .query_abort, .error_push, .error_code,
        .esr_events, .out_buf_avail, .oper_cond, .ques_cond, .cmd_hold,
        .reply_push, .reply_data, .srq, .ist, .irq);
    srs_ctrl_model srs_ctrl_model_i (.clock, .sys_rst, .start, .reply_push,
        .buf_read, .ops_pending, .out_buf_avail);
    // Free-running bench clock.
    always #10 clock = ~clock;
    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle register read; the watcher compares the answer.
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(e);
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask : rd
    // One-cycle pulse on one bit of the pulse vector.
    task automatic pulse(input int k);
        @(posedge clock);
        pul[k] <= 1'b1;
        @(posedge clock);
        pul <= 7'h00;
    endtask : pulse
    // Bounded wait for service request (w=0) or hold (w=1) to reach lvl.
    task automatic await(input int w, input logic lvl);
        n = 0;
        while ((w != 0 ? cmd_hold : srq) !== lvl && n < 50) begin
            @(negedge clock);
            n++;
        end
        // A wait that runs out leaves a mismatch behind.
        check(16'(w != 0 ? cmd_hold : srq), 16'(lvl));
    endtask : await
    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    // Mid-cycle watcher: read data and replies against the oldest notes.
    always @(negedge clock) begin
        if (rd_d)
            check(reg_rdata, rd_q.pop_front());
        if (reply_push === 1'b1)
            check({8'h00, reply_data}, {8'h00, rp_q.pop_front()});
        rd_d = reg_rd;
    end
    // Cuts a hang short.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    // Main sequence.
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        rd(srs_pkg::ADDR_SRE, 16'h0000);
        rd(srs_pkg::ADDR_OPER_PTR, srs_pkg::PTR_RESET);
        rd(8'hFC, 16'h0000);
        $display("reset test done");
        wr(srs_pkg::ADDR_ESE, 16'h0001);
        wr(srs_pkg::ADDR_SRE, 16'h0020);
        pulse(5);
        pulse(0);
        await(0, 1'b1);
        check(16'(srq), 16'h0001);
        rd(srs_pkg::ADDR_STB, 16'h0060);
        wr(srs_pkg::ADDR_IRQ_MASK, 16'h0001);
        rd(srs_pkg::ADDR_IRQ_STAT, 16'h0003);
        @(negedge clock);
        check(16'(irq), 16'h0001);
        wr(srs_pkg::ADDR_IRQ_STAT, 16'h0003);
        repeat (2) @(negedge clock);
        check(16'(irq), 16'h0000);
        rd(srs_pkg::ADDR_ESR, 16'h0001);
        rd(srs_pkg::ADDR_ESR, 16'h0000);
        rd(srs_pkg::ADDR_ESE, 16'h0001);
        await(0, 1'b0);
        check(16'(srq), 16'h0000);
        $display("opc test done");
        wr(srs_pkg::ADDR_SRE, 16'h0010);
        for (int k = 1; k <= 2; k++) begin
            pulse(5);
            if (k == 1)
                rp_q.push_back(srs_pkg::REPLY_DONE);
            pulse(k);
            @(negedge clock);
            check(16'(cmd_hold), 16'h0001);
            await(1, 1'b0);
            check(16'(ops_pending), 16'h0000);
        end
        await(0, 1'b1);
        rd(srs_pkg::ADDR_STB, 16'h0050);
        wr(srs_pkg::ADDR_PPE, 16'h0010);
        repeat (2) @(negedge clock);
        check(16'(ist), 16'h0001);
        wr(srs_pkg::ADDR_PPE, 16'h0001);
        repeat (2) @(negedge clock);
        check(16'(ist), 16'h0000);
        wr(srs_pkg::ADDR_SRE, 16'h0040);
        repeat (3) @(negedge clock);
        check(16'(srq), 16'h0000);
        pulse(6);
        $display("query and wait test done");
        pulse(3);
        code = $random(seed);
        error_code <= code;
        pulse(4);
        rd(srs_pkg::ADDR_STB, 16'h0004);
        rd(srs_pkg::ADDR_ERRQ, srs_pkg::ERR_QUERY_INT);
        rd(srs_pkg::ADDR_ERRQ, code);
        rd(srs_pkg::ADDR_ERRQ, 16'h0000);
        $display("error test done");
        // Random event pulse for one cycle, then summary and read-clear.
        @(posedge clock);
        esr_events <= code[15:8];
        @(posedge clock);
        esr_events <= 8'h00;
        rd(srs_pkg::ADDR_STB, {10'h000, code[8], 5'h00});
        rd(srs_pkg::ADDR_ESR, {8'h00, code[15:8]});
        rd(srs_pkg::ADDR_ESR, 16'h0000);
        wr(srs_pkg::ADDR_OPER_EN, 16'h0001);
        wr(srs_pkg::ADDR_QUES_EN, 16'h0001);
        oper_cond <= 16'h0001;
        ques_cond <= 16'h0001;
        repeat (3) @(posedge clock);
        rd(srs_pkg::ADDR_STB, 16'h0088);
        rd(srs_pkg::ADDR_OPER_EVT, 16'h0001);
        rd(srs_pkg::ADDR_OPER_EVT, 16'h0000);
        repeat (2) @(posedge clock);
        rd(srs_pkg::ADDR_STB, 16'h0008);
        repeat (3) @(posedge clock);
        $display("scpi test done");
        results();
    end
endmodule : srs_status_sync_test
